// file: core/asr_defines.svh
`ifndef ASR_DEFINES_SVH
`define ASR_DEFINES_SVH

`define ASR_CORE_CLK_MHZ   200
`define ASR_REFRESH_NS     1000
`define ASR_REFRESH_CYC    ((`ASR_REFRESH_NS * `ASR_CORE_CLK_MHZ) / 1000)
`define ASR_SSI_TMO_NS     25000
`define ASR_SSI_TMO_CYC    ((`ASR_SSI_TMO_NS * `ASR_CORE_CLK_MHZ + 999) / 1000)
`define ASR_NVM_WAIT_MS    20
`define ASR_NVM_WAIT_CYC   (`ASR_NVM_WAIT_MS * `ASR_CORE_CLK_MHZ * 1000)

`define ASR_FRAME_BITS     16
`define ASR_SSI_LAST_CLK   17
`define ASR_RES_BITS       14
`define ASR_REG_COUNT      32

`define ASR_CMD_READ       3'h2
`define ASR_CMD_WRITE      3'h4
`define ASR_REG_FLAGS      5'h1B

`define ASR_DEF_REG4       8'hC0
`define ASR_DEF_REG5       8'hFF
`define ASR_DEF_REG6       8'h1C
`define ASR_DEF_REG14      8'h77
`define ASR_DEF_REG16      8'h9C

`endif

// file: core/asr_pkg.sv
`default_nettype none
package asr_pkg;

  typedef struct packed {
    logic [2:0] cmd;
    logic [4:0] addr;
    logic [7:0] data;
  } asr_req_type;

  typedef struct packed {
    logic [15:0] angle;
    logic        mag_high;
    logic        mag_low;
  } asr_sample_type;

  typedef enum logic [2:0] {
    ASR_NVM_LOAD   = 3'h1,
    ASR_NVM_IDLE   = 3'h2,
    ASR_NVM_COMMIT = 3'h4
  } asr_nvm_state_type;

  typedef enum logic [1:0] {
    ASR_RESP_ANGLE = 2'h1,
    ASR_RESP_REG   = 2'h2
  } asr_resp_type;

endpackage : asr_pkg
`default_nettype wire

// file: core/asr_sync.sv
`default_nettype none
module asr_sync #(
  parameter int   WIDTH     = 1,
  parameter logic RESET_VAL = 1'h0
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // meta_q feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta_q   <= {WIDTH{RESET_VAL}};
      sync_out <= {WIDTH{RESET_VAL}};
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : asr_sync
`default_nettype wire

// file: core/asr_nvm.sv
`include "asr_defines.svh"
`default_nettype none
module asr_nvm #(
  parameter int unsigned WAIT_CYC = `ASR_NVM_WAIT_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       wr_valid,
  input  wire logic [4:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic [4:0] rd_addr,
  output logic      [7:0] rd_data,
  output logic            busy
);
  import asr_pkg::*;

  localparam int CW = $clog2(WAIT_CYC + 1);

  // the non-volatile array is deliberately outside sys_rst: it survives reset;
  // its factory content is a declaration value so only the commit writes it
  logic              [7:0]    nvm_mem  [`ASR_REG_COUNT] = '{
    4:       `ASR_DEF_REG4,
    5:       `ASR_DEF_REG5,
    6:       `ASR_DEF_REG6,
    14:      `ASR_DEF_REG14,
    16:      `ASR_DEF_REG16,
    default: 8'h00
  };
  logic              [7:0]    shadow_q [`ASR_REG_COUNT];
  asr_nvm_state_type          state_q;
  logic              [4:0]    load_idx_q;
  logic              [CW-1:0] wait_q;
  logic              [4:0]    pend_addr_q;
  logic              [7:0]    pend_data_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q     <= ASR_NVM_LOAD;
      load_idx_q  <= 5'h0;
      wait_q      <= '0;
      pend_addr_q <= 5'h0;
      pend_data_q <= 8'h00;
    end else begin
      case (state_q)
        ASR_NVM_LOAD: begin
          load_idx_q <= load_idx_q + 5'h1;
          if (load_idx_q == 5'h1F) begin
            state_q <= ASR_NVM_IDLE;
          end
        end
        ASR_NVM_IDLE: begin
          if (wr_valid) begin
            state_q     <= ASR_NVM_COMMIT;
            wait_q      <= '0;
            pend_addr_q <= wr_addr;
            pend_data_q <= wr_data;
          end
        end
        ASR_NVM_COMMIT: begin
          wait_q <= wait_q + CW'(1);
          if (wait_q == CW'(WAIT_CYC - 1)) begin
            state_q <= ASR_NVM_IDLE;
          end
        end
        default: state_q <= ASR_NVM_IDLE;
      endcase
    end
  end

  // power-on copy out of the array, then commit of a write after the full wait
  always_ff @(posedge core_clk) begin
    if (state_q == ASR_NVM_LOAD) begin
      shadow_q[load_idx_q] <= nvm_mem[load_idx_q];
    end else if (state_q == ASR_NVM_COMMIT && wait_q == CW'(WAIT_CYC - 1)) begin
      nvm_mem[pend_addr_q]  <= pend_data_q;
      shadow_q[pend_addr_q] <= pend_data_q;
    end
  end

  // until the commit, readback still shows the old content
  assign rd_data = shadow_q[rd_addr];
  assign busy    = (state_q != ASR_NVM_IDLE);
endmodule : asr_nvm
`default_nettype wire

// file: core/asr_top.sv
// What this block does
// - reload angle buffer every microsecond unless frozen
// - chip select falling freezes buffer for frame
// - chip select rising releases buffer, updates resume
// - sixteen clocks shift angle out MSB first
// - pad bits below resolution with zeros
// - short frames give truncated MSB-first angle
// - fast reads repeat angle until refreshed
// - next frame returns register in upper byte
// - writes go to NVM, restored at power-on
// - next frame after write echoes stored value
// - early readback after write shows old value
// - SSI link reads angle only
// - SSI rising clock starts, first is dummy
// - SSI sends MSB first from second clock
// - SSI buffer frozen until last fall plus timeout
// - SPI modes 0 and 3 auto-detected
`include "asr_defines.svh"
`default_nettype none
module asr_top
  import asr_pkg::*;
#(
  parameter int unsigned RES_BITS    = `ASR_RES_BITS,
  parameter int unsigned REFRESH_CYC = `ASR_REFRESH_CYC,
  parameter int unsigned SSI_TMO_CYC = `ASR_SSI_TMO_CYC,
  parameter int unsigned NVM_WAIT    = `ASR_NVM_WAIT_CYC
) (
  input  wire logic           core_clk,
  input  wire logic           sys_rst,
  input  wire asr_pkg::asr_sample_type sample,
  input  wire logic           spi_clk,
  input  wire logic           cs_n,
  input  wire logic           mosi,
  output logic                miso,
  output logic                miso_oe,
  input  wire logic           ssck,
  output logic                ssd
);
  import asr_pkg::*;

  localparam int RC = $clog2(REFRESH_CYC + 1);
  localparam int TC = $clog2(SSI_TMO_CYC + 1);
  localparam logic [15:0] RES_MASK = 16'(~((32'h1 << (16 - RES_BITS)) - 32'h1));

  // ---- spi link domain (master clock, stands still between frames)
  logic [4:0]  rx_cnt_q;
  logic [14:0] rx_sh_q;
  logic [4:0]  tx_idx_q;
  logic [15:0] done_word_q;
  logic        done_tgl_q;
  logic [15:0] tx_word_q;
  logic [3:0]  tx_bit;

  // capture on rising edge in both modes; cs_n high clears the frame state
  always_ff @(posedge spi_clk or posedge cs_n) begin
    if (cs_n) begin
      rx_cnt_q <= 5'h0;
      rx_sh_q  <= 15'h0;
    end else begin
      if (rx_cnt_q != 5'(`ASR_FRAME_BITS)) begin
        rx_cnt_q <= rx_cnt_q + 5'h1;
      end
      rx_sh_q <= {rx_sh_q[13:0], mosi};
    end
  end

  // only a sixteenth rising edge publishes a request word
  always_ff @(posedge spi_clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_word_q <= 16'h0000;
      done_tgl_q  <= 1'h0;
    end else if (!cs_n && rx_cnt_q == 5'(`ASR_FRAME_BITS - 1)) begin
      done_word_q <= {rx_sh_q, mosi};
      done_tgl_q  <= ~done_tgl_q;
    end
  end

  // mode 3 sees its first falling edge before any rising edge, so the index
  // is the count of rising edges; mode 0 shows the MSB straight from cs fall
  always_ff @(negedge spi_clk or posedge cs_n) begin
    if (cs_n) begin
      tx_idx_q <= 5'h0;
    end else begin
      tx_idx_q <= rx_cnt_q;
    end
  end

  assign tx_bit  = 4'hF - tx_idx_q[3:0];
  // tx_word_q is settled a few core cycles after cs fall, well before the
  // first master edge; it stays put until the next frame
  assign miso    = (tx_idx_q < 5'(`ASR_FRAME_BITS)) ? tx_word_q[tx_bit] : 1'h0;
  assign miso_oe = ~cs_n;

  // ---- core domain
  logic         cs_s;
  logic         cs_prev_q;
  logic         tgl_s;
  logic         tgl_prev_q;
  logic         ssck_s;
  logic         ssck_prev_q;
  logic         cs_fall;
  logic         cs_rise;
  logic         new_word;
  asr_req_type  req_q;
  asr_req_type  req_now;
  logic         seen_q;
  logic         seen_now;
  asr_resp_type resp_q;
  logic [4:0]   resp_addr_q;
  logic         wr_valid;
  logic [7:0]   nvm_rd;
  logic [7:0]   reg_rd;
  logic         nvm_busy;
  logic [15:0]  angle_buf_q;
  logic [RC-1:0] refresh_q;
  logic         ssi_active_q;
  logic [4:0]   ssi_cnt_q;
  logic [15:0]  ssi_word_q;
  logic [TC-1:0] ssi_tmo_q;
  logic         ssi_timing_q;
  logic         ssck_rise;
  logic         ssck_fall;

  asr_sync #(.WIDTH(1), .RESET_VAL(1'h1)) u_cs_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (cs_n),
    .sync_out (cs_s)
  );

  asr_sync #(.WIDTH(1), .RESET_VAL(1'h0)) u_tgl_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (done_tgl_q),
    .sync_out (tgl_s)
  );

  asr_sync #(.WIDTH(1), .RESET_VAL(1'h0)) u_ssck_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (ssck),
    .sync_out (ssck_s)
  );

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cs_prev_q   <= 1'h1;
      tgl_prev_q  <= 1'h0;
      ssck_prev_q <= 1'h0;
    end else begin
      cs_prev_q   <= cs_s;
      tgl_prev_q  <= tgl_s;
      ssck_prev_q <= ssck_s;
    end
  end

  assign cs_fall   = cs_prev_q & ~cs_s;
  assign cs_rise   = ~cs_prev_q & cs_s;
  assign new_word  = tgl_s ^ tgl_prev_q;
  assign ssck_rise = ~ssck_prev_q & ssck_s;
  assign ssck_fall = ssck_prev_q & ~ssck_s;
  // the word toggle and cs rise may land in the same core cycle
  assign seen_now  = seen_q | new_word;
  assign req_now   = new_word ? asr_req_type'(done_word_q) : req_q;

  // done_word_q is quiet for at least a frame after its toggle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      req_q  <= '0;
      seen_q <= 1'h0;
    end else begin
      if (new_word) begin
        req_q <= asr_req_type'(done_word_q);
      end
      if (cs_fall) begin
        seen_q <= 1'h0;
      end else if (new_word) begin
        seen_q <= 1'h1;
      end
    end
  end

  // what the next frame carries is decided when this frame closes
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      resp_q      <= ASR_RESP_ANGLE;
      resp_addr_q <= 5'h0;
    end else if (cs_rise) begin
      resp_addr_q <= req_now.addr;
      if (seen_now && (req_now.cmd == `ASR_CMD_READ || req_now.cmd == `ASR_CMD_WRITE)) begin
        resp_q <= ASR_RESP_REG;
      end else begin
        resp_q <= ASR_RESP_ANGLE;
      end
    end
  end

  // a write that arrives while the store is busy is dropped
  assign wr_valid = cs_rise && seen_now && req_now.cmd == `ASR_CMD_WRITE && !nvm_busy;

  asr_nvm #(.WAIT_CYC(NVM_WAIT)) u_nvm (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .wr_valid (wr_valid),
    .wr_addr  (req_now.addr),
    .wr_data  (req_now.data),
    .rd_addr  (resp_addr_q),
    .rd_data  (nvm_rd),
    .busy     (nvm_busy)
  );

  // the flag register reflects live field detection, not stored content
  assign reg_rd = (resp_addr_q == `ASR_REG_FLAGS) ? {sample.mag_high, sample.mag_low, 6'h00} : nvm_rd;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_word_q <= 16'h0000;
    end else if (cs_fall) begin
      if (resp_q == ASR_RESP_REG) begin
        tx_word_q <= {reg_rd, 8'h00};
      end else begin
        tx_word_q <= angle_buf_q;
      end
    end
  end

  // periodic reload; spi frame holds it from cs fall until cs rise
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      refresh_q   <= '0;
      angle_buf_q <= 16'h0000;
    end else begin
      if (refresh_q == RC'(REFRESH_CYC - 1)) begin
        refresh_q <= '0;
      end else begin
        refresh_q <= refresh_q + RC'(1);
      end
      if (refresh_q == RC'(REFRESH_CYC - 1) && cs_s && !cs_fall) begin
        angle_buf_q <= sample.angle & RES_MASK;
      end
    end
  end

  // ---- ssi read path, sampled through the synchroniser
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ssi_active_q <= 1'h0;
      ssi_cnt_q    <= 5'h0;
      ssi_word_q   <= 16'h0000;
      ssd          <= 1'h0;
    end else if (ssck_rise) begin
      if (!ssi_active_q) begin
        ssi_active_q <= 1'h1;
        ssi_cnt_q    <= 5'h1;
        ssi_word_q   <= angle_buf_q;
      end else if (ssi_cnt_q != 5'(`ASR_SSI_LAST_CLK)) begin
        ssi_cnt_q <= ssi_cnt_q + 5'h1;
        ssd       <= ssi_word_q[4'hF - 4'(ssi_cnt_q - 5'h1)];
      end else begin
        ssd <= 1'h0;
      end
    end else if (ssi_active_q && ssi_timing_q && ssi_tmo_q == '0) begin
      ssi_active_q <= 1'h0;
      ssi_cnt_q    <= 5'h0;
      ssd          <= 1'h0;
    end
  end

  // timeout restarts on every falling clock, so short reads release too
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ssi_tmo_q    <= '0;
      ssi_timing_q <= 1'h0;
    end else if (ssck_rise) begin
      ssi_timing_q <= 1'h0;
    end else if (ssck_fall && ssi_active_q) begin
      ssi_tmo_q    <= TC'(SSI_TMO_CYC - 1);
      ssi_timing_q <= 1'h1;
    end else if (ssi_timing_q) begin
      if (ssi_tmo_q == '0) begin
        ssi_timing_q <= 1'h0;
      end else begin
        ssi_tmo_q <= ssi_tmo_q - TC'(1);
      end
    end
  end
endmodule : asr_top
`default_nettype wire

// file: verif/asr_props.sv
`default_nettype none
module asr_props #(
  parameter int unsigned RES_BITS    = 14,
  parameter int unsigned SSI_TMO_CYC = 20
) (
  input wire logic                   core_clk,
  input wire logic                   sys_rst,
  input wire asr_pkg::asr_sample_type sample,
  input wire logic                   spi_clk,
  input wire logic                   cs_n,
  input wire logic                   mosi,
  input wire logic                   miso,
  input wire logic                   miso_oe,
  input wire logic                   ssck,
  input wire logic                   ssd
);
  import asr_pkg::*;
  logic [4:0]  bit_q;
  logic [4:0]  rise_q;
  logic        ssck_q;
  logic [15:0] low_q;
  logic [15:0] since_q;
  wire logic   rise = ssck && !ssck_q;

  // chip select clears the count asynchronously, like the frame itself
  always_ff @(posedge spi_clk or posedge cs_n) begin
    if (cs_n) bit_q <= 5'h0;
    else if (bit_q != 5'h1f) bit_q <= bit_q + 5'h1;
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) ssck_q <= 1'b0;
    else ssck_q <= ssck;
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst || ssck) low_q <= 16'h0000;
    else if (low_q != 16'hffff) low_q <= low_q + 16'h0001;
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst || rise) since_q <= 16'h0000;
    else if (since_q != 16'hffff) since_q <= since_q + 16'h0001;
  end
  // margin of 8 keeps the release well past the design's synchroniser lag
  always_ff @(posedge core_clk) begin
    if (sys_rst) rise_q <= 5'h0;
    else if (rise) rise_q <= rise_q + 5'h1;
    else if (low_q > 16'(SSI_TMO_CYC + 8)) rise_q <= 5'h0;
  end

  AST_OE_CS: assert property (@(posedge core_clk) disable iff (sys_rst)
    miso_oe == !cs_n) else $error("miso_oe does not follow chip select");
  AST_MISO_HELD: assert property (@(posedge core_clk) disable iff (sys_rst)
    spi_clk && $past(spi_clk) && !cs_n && !$past(cs_n) && !$past(cs_n, 6) |-> $stable(miso))
    else $error("miso moved while spi clock high");
  AST_SPI_PAD: assert property (@(posedge spi_clk) disable iff (cs_n)
    bit_q >= 5'(RES_BITS) |-> !miso) else $error("miso pad bit not zero");
  AST_SSD_RST: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(sys_rst) |-> !ssd) else $error("ssd not low after reset");
  AST_SSD_DUMMY: assert property (@(posedge core_clk) disable iff (sys_rst)
    rise && rise_q == 5'h0 |-> (!ssd) [*8]) else $error("ssd driven on start clock");
  AST_SSD_PAD: assert property (@(posedge core_clk) disable iff (sys_rst)
    rise && rise_q >= 5'(RES_BITS + 1) |-> ##6 !ssd) else $error("ssd pad bit not zero");
  AST_SSD_EDGE: assert property (@(posedge core_clk) disable iff (sys_rst)
    $changed(ssd) |-> since_q <= 16'h0006 || low_q >= 16'(SSI_TMO_CYC))
    else $error("ssd changed away from a clock rise");
  AST_SSD_IDLE: assert property (@(posedge core_clk) disable iff (sys_rst)
    low_q > 16'(SSI_TMO_CYC + 8) |-> !ssd) else $error("ssd not idle after timeout");

  cover property (@(posedge core_clk) $fell(cs_n));
  cover property (@(posedge core_clk) rise && rise_q == 5'h10);
  cover property (@(posedge core_clk) ssd);
endmodule : asr_props

bind asr_top asr_props #(.RES_BITS(RES_BITS), .SSI_TMO_CYC(SSI_TMO_CYC)) u_asr_props (
  .core_clk(core_clk), .sys_rst(sys_rst), .sample(sample), .spi_clk(spi_clk),
  .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .ssck(ssck), .ssd(ssd));
`default_nettype wire

// file: verif/asr_master.sv
`default_nettype none
module asr_master (
  output logic      spi_clk,
  output logic      cs_n,
  output logic      mosi,
  output logic      ssck,
  input  wire logic miso,
  input  wire logic ssd
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam realtime HALF = 62.5;

  initial begin
    spi_clk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    ssck = 1'b0;
  end

  // mosi falls to its pull-down level outside frames
  task automatic spi_xfer(input logic [15:0] tx, input int n, input logic mode3, output logic [15:0] rx);
    rx = 16'h0000;
    spi_clk = mode3;
    #HALF cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      #HALF spi_clk = 1'b0;
      mosi = tx[15-i];
      #HALF spi_clk = 1'b1;
      rx[15-i] = miso;
    end
    #HALF spi_clk = mode3;
    #HALF cs_n = 1'b1;
    mosi = 1'b0;
    #1000;
  endtask : spi_xfer

  task automatic ssi_xfer(input int n, output logic [15:0] rx);
    rx = 16'h0000;
    for (int k = 1; k <= n; k++) begin
      ssck = 1'b1;
      #HALF;
      if (k >= 2) rx[17-k] = ssd;
      ssck = 1'b0;
      #HALF;
    end
    #40000;
  endtask : ssi_xfer
endmodule : asr_master
`default_nettype wire

// file: verif/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import asr_pkg::*;
  localparam int unsigned RES  = 14;
  localparam int unsigned RCYC = 10;
  localparam int unsigned TMO  = 20;
  // must outlast the 1000 ns idle up to the next cs fall so an early readback is early
  localparam int unsigned NVM  = 400;
  localparam logic [15:0] MASK = 16'hffff << (16 - RES);
  logic           core_clk, sys_rst, spi_clk, cs_n, mosi, miso, miso_oe, ssck, ssd;
  asr_sample_type sample;
  int             errors, tests_run;
  logic [15:0]    rx;
  logic [4:0]     addr_tab [5] = '{5'h04, 5'h05, 5'h06, 5'h0e, 5'h10};
  logic [7:0]     dflt_tab [5] = '{8'hc0, 8'hff, 8'h1c, 8'h77, 8'h9c};

  asr_top #(.RES_BITS(RES), .REFRESH_CYC(RCYC), .SSI_TMO_CYC(TMO), .NVM_WAIT(NVM)) u_asr_top (
    .core_clk(core_clk), .sys_rst(sys_rst), .sample(sample), .spi_clk(spi_clk), .cs_n(cs_n),
    .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .ssck(ssck), .ssd(ssd));
  asr_master u_asr_master (.spi_clk(spi_clk), .cs_n(cs_n), .mosi(mosi), .ssck(ssck),
    .miso(miso), .ssd(ssd));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic finish_test();
    if (errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  task automatic do_reset();
    @(posedge core_clk) sys_rst <= 1'b1;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (50) @(posedge core_clk);
  endtask : do_reset

  // waits out one refresh period so the buffer holds the new sample
  task automatic put(input logic [15:0] a, input logic h, input logic l);
    @(posedge core_clk) sample <= '{angle: a, mag_high: h, mag_low: l};
    repeat (RCYC + 4) @(posedge core_clk);
  endtask : put

  task automatic xs(input logic [15:0] tx, input int n, input logic m3);
    u_asr_master.spi_xfer(tx, n, m3, rx);
  endtask : xs

  task automatic t_angle();
    put(16'ha5c3, 1'b0, 1'b0);
    for (int m = 0; m < 2; m++) begin
      xs(16'h0000, 16, m[0]);
      check(rx, 16'ha5c3 & MASK);
    end
    xs(16'h0000, 8, 1'b0);
    check(rx, 16'ha500);
  endtask : t_angle

  task automatic t_freeze();
    put(16'h1234, 1'b0, 1'b0);
    fork
      xs(16'h0000, 16, 1'b0);
      begin
        #400;
        @(posedge core_clk) sample.angle <= 16'hfedc;
      end
    join
    check(rx, 16'h1234 & MASK);
    repeat (RCYC + 4) @(posedge core_clk);
    xs(16'h0000, 16, 1'b1);
    check(rx, 16'hfedc & MASK);
  endtask : t_freeze

  task automatic t_regread();
    for (int i = 0; i < 5; i++) begin
      xs({3'h2, addr_tab[i], 8'h00}, 16, 1'b0);
      xs(16'h0000, 16, 1'b0);
      check(rx, {dflt_tab[i], 8'h00});
    end
    put(16'h4321, 1'b1, 1'b0);
    xs({3'h2, 5'h1b, 8'h00}, 16, 1'b0);
    xs(16'h0000, 16, 1'b0);
    check(rx, 16'h8000);
  endtask : t_regread

  task automatic t_write();
    xs({3'h4, 5'h09, 8'h80}, 16, 1'b0);
    xs(16'h0000, 16, 1'b0);
    check(rx, 16'h0000);
    repeat (NVM + 10) @(posedge core_clk);
    xs({3'h4, 5'h02, 8'h5a}, 16, 1'b1);
    repeat (NVM + 10) @(posedge core_clk);
    xs(16'h0000, 16, 1'b1);
    check(rx, 16'h5a00);
    xs({3'h2, 5'h09, 8'h00}, 16, 1'b0);
    xs(16'h0000, 16, 1'b0);
    check(rx, 16'h8000);
  endtask : t_write

  task automatic t_refuse();
    xs({3'h7, 5'h04, 8'haa}, 16, 1'b0);
    xs(16'h0000, 16, 1'b0);
    check(rx, 16'h4321 & MASK);
    xs({3'h2, 5'h04, 8'h00}, 8, 1'b0);
    xs(16'h0000, 16, 1'b0);
    check(rx, 16'h4321 & MASK);
    xs({3'h2, 5'h04, 8'h00}, 16, 1'b0);
    xs(16'h0000, 16, 1'b0);
    check(rx, 16'hc000);
  endtask : t_refuse

  task automatic t_restore();
    do_reset();
    xs({3'h2, 5'h02, 8'h00}, 16, 1'b0);
    xs(16'h0000, 16, 1'b0);
    check(rx, 16'h5a00);
  endtask : t_restore

  task automatic t_ssi();
    put(16'h9abd, 1'b0, 1'b0);
    fork
      u_asr_master.ssi_xfer(17, rx);
      begin
        #600;
        @(posedge core_clk) sample.angle <= 16'h0f0f;
      end
    join
    check(rx, 16'h9abd & MASK);
    u_asr_master.ssi_xfer(17, rx);
    check(rx, 16'h0f0f & MASK);
  endtask : t_ssi

  initial begin
    sys_rst = 1'b1;
    sample = '0;
    errors = 0;
    tests_run = 0;
    do_reset();
    t_angle();
    t_freeze();
    t_regread();
    t_write();
    t_refuse();
    t_restore();
    t_ssi();
    finish_test();
  end

  // run needs about 186 us; anything far beyond that is a hang
  initial begin
    #400us;
    errors++;
    finish_test();
  end
endmodule : tb
`default_nettype wire
